// file: logic/muldiv_pkg.sv
// shared constants and types of the multiply/divide unit
package muldiv_pkg;

    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int DWORD_W = 64;
    localparam int DIV_STEPS = 32;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(DIV_STEPS - 1);
    localparam logic [WORD_W-1:0] QUO_NEG_LIMIT = 32'h80000000;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_UNIT_STATE = 8'h10;
    localparam int EV_W = 2;
    localparam int EV_DONE_BIT = 0;
    localparam int EV_EXC_BIT = 1;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'h1;
    localparam logic [EV_W-1:0] IRQ_EN_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        multiply_memory_half,
        multiply_memory_word,
        multiply_register_pair,
        multiply_immediate_op,
        divide_memory_byte,
        divide_memory_half,
        divide_memory_word
    } op_t;

    typedef struct packed {
        logic [WORD_W-1:0] even;
        logic [WORD_W-1:0] odd;
    } pair_t;

    typedef struct packed {
        logic flag_arith_exception;
        logic flag_positive;
        logic flag_negative;
        logic flag_zero;
    } flags_t;

    localparam flags_t EXC_FLAGS = 4'h8;

    function automatic logic op_is_div(input op_t o);
        op_is_div = (o == divide_memory_byte) || (o == divide_memory_half) ||
                    (o == divide_memory_word);
    endfunction

endpackage

// file: logic/div_step.sv
// one restoring step of the unsigned magnitude divider
`timescale 1ns/10ps
`default_nettype none
module div_step (
    input wire logic [31:0] rem_in,
    input wire logic bit_in,
    input wire logic [31:0] divisor,
    output logic [31:0] rem_out,
    output logic quo_bit
);
    logic [32:0] shifted;
    logic [32:0] diff;

    // rem_in < divisor holds, so a non-negative difference fits 32 bits
    always_comb begin
        shifted = {rem_in, bit_in};
        diff = shifted - {1'h0, divisor};
        quo_bit = ~diff[32];
        rem_out = quo_bit ? diff[31:0] : shifted[31:0];
    end
endmodule // div_step
`default_nettype wire

// file: logic/muldiv_unit.sv
// fixed-point multiply/divide execution unit with register slave
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module muldiv_unit (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    input wire muldiv_pkg::op_t op,
    input wire logic [31:0] mem_operand,
    input wire logic [15:0] imm_half,
    input wire logic [31:0] src_reg,
    input wire muldiv_pkg::pair_t pair_in,
    output muldiv_pkg::pair_t result,
    output muldiv_pkg::flags_t flags,
    output logic done,
    output logic busy,
    output logic irq,
    input wire logic [muldiv_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [muldiv_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import muldiv_pkg::*;

    typedef enum {s_idle, s_div, s_end} state_t;

    state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;
    op_t op_ff;
    pair_t dvd_ff, result_ff;
    flags_t flags_ff;
    logic done_ff, busy_ff, qneg_ff, rneg_ff, ctrl_en_ff, irq_ff;
    logic [WORD_W-1:0] rem_ff, quo_ff, dvs_ff, step_rem;
    logic step_q, take, is_div, pre_ovf, q_ovf;
    logic [WORD_W-1:0] opnd, mag_dvs, q_val, r_val;
    logic [DWORD_W-1:0] mag_dvd;
    logic signed [DWORD_W-1:0] prod;

    // -------------------------------------------------------------
    // operand formation
    // -------------------------------------------------------------
    always_comb begin
        case (op)
            multiply_memory_half, divide_memory_half:
                opnd = {{HALF_W{mem_operand[HALF_W-1]}},
                        mem_operand[HALF_W-1:0]};
            multiply_immediate_op:
                opnd = {{HALF_W{imm_half[HALF_W-1]}}, imm_half};
            multiply_register_pair: opnd = src_reg;
            divide_memory_byte:
                opnd = {{(WORD_W-BYTE_W){1'h0}},
                        mem_operand[BYTE_W-1:0]};
            default: opnd = mem_operand;
        endcase
    end

    // pair_in.odd is the implicit partner of the even register
    assign prod = $signed(opnd) * $signed(pair_in.odd);
    assign is_div = op_is_div(op);
    assign take = (state_ff == s_idle) && start && ctrl_en_ff;
    assign mag_dvd = pair_in[DWORD_W-1] ? -pair_in : pair_in;
    assign mag_dvs = opnd[WORD_W-1] ? -opnd : opnd;
    // quotient would need more than 32 bits, or divisor is zero
    assign pre_ovf = (mag_dvs == '0) ||
                     (mag_dvd[DWORD_W-1:WORD_W] >= mag_dvs);

    div_step u_step (
        .rem_in(rem_ff),
        .bit_in(quo_ff[WORD_W-1]),
        .divisor(dvs_ff),
        .rem_out(step_rem),
        .quo_bit(step_q)
    );

    // zero magnitude stays zero whatever the sign
    assign q_val = qneg_ff ? -quo_ff : quo_ff;
    assign r_val = rneg_ff ? -rem_ff : rem_ff;
    // a negative quotient may reach one further than a positive one
    assign q_ovf = qneg_ff ? (quo_ff > QUO_NEG_LIMIT) : quo_ff[WORD_W-1];

    function automatic flags_t sign_flags(input logic neg, input logic zr);
        sign_flags = '{flag_arith_exception: 1'h0,
                       flag_positive: !neg && !zr,
                       flag_negative: neg,
                       flag_zero: zr};
    endfunction

    // -------------------------------------------------------------
    // sequencing
    // -------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= s_idle;
            cnt_ff <= '0;
            op_ff <= multiply_memory_half;
            dvd_ff <= '0;
            result_ff <= '0;
            flags_ff <= '0;
            done_ff <= 1'h0;
            busy_ff <= 1'h0;
            rem_ff <= '0;
            quo_ff <= '0;
            dvs_ff <= '0;
            qneg_ff <= 1'h0;
            rneg_ff <= 1'h0;
        end else begin
            done_ff <= 1'h0;
            case (state_ff)
                s_idle: if (take) begin
                    op_ff <= op;
                    dvd_ff <= pair_in;
                    if (!is_div) begin
                        result_ff <= prod;
                        flags_ff <= sign_flags(prod[DWORD_W-1],
                                               prod == '0);
                        done_ff <= 1'h1;
                    end else if (pre_ovf) begin
                        result_ff <= pair_in;
                        flags_ff <= EXC_FLAGS;
                        done_ff <= 1'h1;
                    end else begin
                        rem_ff <= mag_dvd[DWORD_W-1:WORD_W];
                        quo_ff <= mag_dvd[WORD_W-1:0];
                        dvs_ff <= mag_dvs;
                        qneg_ff <= pair_in[DWORD_W-1] ^ opnd[WORD_W-1];
                        rneg_ff <= pair_in[DWORD_W-1];
                        cnt_ff <= '0;
                        busy_ff <= 1'h1;
                        state_ff <= s_div;
                    end
                end
                s_div: begin
                    rem_ff <= step_rem;
                    quo_ff <= {quo_ff[WORD_W-2:0], step_q};
                    cnt_ff <= cnt_ff + 1'h1;
                    if (cnt_ff == DIV_LAST) begin
                        state_ff <= s_end;
                    end
                end
                s_end: begin
                    state_ff <= s_idle;
                    busy_ff <= 1'h0;
                    done_ff <= 1'h1;
                    if (q_ovf) begin
                        result_ff <= dvd_ff;
                        flags_ff <= EXC_FLAGS;
                    end else begin
                        result_ff <= '{even: r_val, odd: q_val};
                        flags_ff <= sign_flags(q_val[WORD_W-1],
                                               q_val == '0);
                    end
                end
                default: state_ff <= s_idle;
            endcase
        end
    end

    assign result = result_ff;
    assign flags = flags_ff;
    assign done = done_ff;
    assign busy = busy_ff;

    // -------------------------------------------------------------
    // register slave
    // -------------------------------------------------------------
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, wlane_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [WORD_W-1:0] wdata_ff, rdata_ff, rd_mux;
    logic [1:0] bresp_ff, rresp_ff;
    logic [EV_W-1:0] status_ff, irq_en_ff, nxt_status, events;
    logic wr_fire, wr_hit, rd_hit;

    // both halves of a write held, no response pending
    assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_hit = (awaddr_ff == OFS_STATUS) || (awaddr_ff == OFS_IRQ_EN) ||
                    (awaddr_ff == OFS_IRQ_CLR) || (awaddr_ff == OFS_CTRL) ||
                    (awaddr_ff == OFS_UNIT_STATE);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            awready_ff <= 1'h1;
            wready_ff <= 1'h1;
            bvalid_ff <= 1'h0;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wlane_ff <= 1'h0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awready_ff <= 1'h0;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                wready_ff <= 1'h0;
                wdata_ff <= s_axi_wdata;
                wlane_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                bvalid_ff <= 1'h1;
                bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'h0;
                awready_ff <= 1'h1;
                wready_ff <= 1'h1;
            end
        end
    end

    // only byte lane 0 carries writable bits
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_en_ff <= IRQ_EN_RST;
            ctrl_en_ff <= CTRL_EN_RST;
        end else if (wr_fire && wlane_ff) begin
            if (awaddr_ff == OFS_IRQ_EN) begin
                irq_en_ff <= wdata_ff[EV_W-1:0];
            end
            if (awaddr_ff == OFS_CTRL) begin
                ctrl_en_ff <= wdata_ff[CTRL_EN_BIT];
            end
        end
    end

    // a new event beats a clear in the same cycle
    always_comb begin
        events = '0;
        events[EV_DONE_BIT] = done_ff;
        events[EV_EXC_BIT] = done_ff && flags_ff.flag_arith_exception;
        nxt_status = status_ff;
        if (wr_fire && wlane_ff && awaddr_ff == OFS_IRQ_CLR) begin
            nxt_status = status_ff & ~wdata_ff[EV_W-1:0];
        end
        nxt_status = nxt_status | events;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status_ff <= '0;
            irq_ff <= 1'h0;
        end else begin
            status_ff <= nxt_status;
            irq_ff <= |(nxt_status & irq_en_ff);
        end
    end

    always_comb begin
        rd_hit = 1'h1;
        case (s_axi_araddr)
            OFS_STATUS: rd_mux = WORD_W'(status_ff);
            OFS_IRQ_EN: rd_mux = WORD_W'(irq_en_ff);
            OFS_IRQ_CLR: rd_mux = '0;
            OFS_CTRL: rd_mux = WORD_W'(ctrl_en_ff);
            OFS_UNIT_STATE: rd_mux = WORD_W'({busy_ff, flags_ff});
            default: begin
                rd_mux = '0;
                rd_hit = 1'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            arready_ff <= 1'h1;
            rvalid_ff <= 1'h0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_ff) begin
                arready_ff <= 1'h0;
                rvalid_ff <= 1'h1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'h0;
                arready_ff <= 1'h1;
            end
        end
    end

    assign irq = irq_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    logic [WORD_W-1:0] chk_mem_ff, chk_src_ff;
    logic [HALF_W-1:0] chk_imm_ff;
    logic signed [WORD_W-1:0] chk_dvs_ff;
    logic chk_small_ff, mul_done, div_ok;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chk_mem_ff <= '0;
            chk_src_ff <= '0;
            chk_imm_ff <= '0;
            chk_dvs_ff <= '0;
            chk_small_ff <= 1'h0;
        end else if (take) begin
            chk_mem_ff <= mem_operand;
            chk_src_ff <= src_reg;
            chk_imm_ff <= imm_half;
            chk_dvs_ff <= opnd;
            chk_small_ff <= mag_dvd < {{WORD_W{1'h0}}, mag_dvs};
        end
    end

    assign mul_done = done_ff && !op_is_div(op_ff);
    assign div_ok = done_ff && op_is_div(op_ff) &&
                    !flags_ff.flag_arith_exception;

    sequence s_div_take;
        take && is_div;
    endsequence
    sequence s_div_done;
        ##[1:34] done_ff;
    endsequence

    a_mul_half_prod: assert property (
        mul_done && op_ff == multiply_memory_half
        |-> $signed(result_ff) == $signed({{HALF_W{chk_mem_ff[HALF_W-1]}},
            chk_mem_ff[HALF_W-1:0]}) * $signed(dvd_ff.odd))
        else $error("halfword product wrong");
    a_mul_word_prod: assert property (
        mul_done && op_ff == multiply_memory_word
        |-> $signed(result_ff) == $signed(chk_mem_ff) * $signed(dvd_ff.odd))
        else $error("word product wrong");
    a_mul_imm_prod: assert property (
        mul_done && op_ff == multiply_immediate_op
        |-> $signed(result_ff) == $signed({{HALF_W{chk_imm_ff[HALF_W-1]}},
            chk_imm_ff}) * $signed(dvd_ff.odd))
        else $error("immediate product wrong");
    a_mul_reg_prod: assert property (
        mul_done && op_ff == multiply_register_pair
        |-> $signed(result_ff) == $signed(chk_src_ff) * $signed(dvd_ff.odd))
        else $error("register product wrong");
    a_mul_no_exc: assert property (take && !is_div
        |=> done_ff && !flags_ff.flag_arith_exception)
        else $error("multiply raised exception");
    a_mul_flags_set: assert property (mul_done
        |-> $onehot({flags_ff.flag_positive, flags_ff.flag_negative,
            flags_ff.flag_zero}) &&
            flags_ff.flag_negative == result_ff[DWORD_W-1] &&
            flags_ff.flag_zero == (result_ff == '0))
        else $error("multiply flags wrong");
    a_div_byte_zext: assert property (
        (s_div_take and op == divide_memory_byte)
        |=> chk_dvs_ff == {{(WORD_W-BYTE_W){1'h0}}, chk_mem_ff[BYTE_W-1:0]})
        else $error("byte divisor not zero extended");
    a_div_half_sext: assert property (
        (s_div_take and op == divide_memory_half)
        |=> chk_dvs_ff == {{HALF_W{chk_mem_ff[HALF_W-1]}},
            chk_mem_ff[HALF_W-1:0]})
        else $error("halfword divisor not sign extended");
    a_div_word_used: assert property (
        (s_div_take and op == divide_memory_word)
        |=> chk_dvs_ff == chk_mem_ff)
        else $error("word divisor wrong");
    a_div_result_pair: assert property (div_ok
        |-> $signed(dvd_ff) == $signed(result_ff.odd) * chk_dvs_ff +
            $signed(result_ff.even))
        else $error("quotient and remainder inconsistent");
    a_div_rem_sign: assert property (div_ok && result_ff.even != '0
        |-> result_ff.even[WORD_W-1] == dvd_ff[DWORD_W-1])
        else $error("remainder sign wrong");
    a_div_quo_sign: assert property (div_ok && result_ff.odd != '0
        |-> result_ff.odd[WORD_W-1] ==
            (dvd_ff[DWORD_W-1] ^ chk_dvs_ff[WORD_W-1]))
        else $error("quotient sign wrong");
    a_div_small_zero: assert property (div_ok && chk_small_ff
        |-> result_ff.odd == '0)
        else $error("small dividend quotient not zero");
    a_div_exc_keep: assert property (
        done_ff && flags_ff.flag_arith_exception
        |-> op_is_div(op_ff) && result_ff == dvd_ff)
        else $error("dividend not kept on exception");
    a_div_flags_set: assert property (div_ok
        |-> flags_ff.flag_zero == (result_ff.odd == '0) &&
            flags_ff.flag_negative == result_ff.odd[WORD_W-1] &&
            $onehot({flags_ff.flag_positive, flags_ff.flag_negative,
            flags_ff.flag_zero}))
        else $error("divide flags wrong");
    a_div_done_time: assert property (s_div_take |-> s_div_done)
        else $error("divide did not finish");

endmodule // muldiv_unit
`default_nettype wire

// file: sim/seq_model.sv
// sequencer partner: issues unit requests and waits for done
`timescale 1ns/10ps
`default_nettype none
module seq_model
    import muldiv_pkg::*;
(
    input wire logic mclk,
    input wire logic done,
    output logic start,
    output muldiv_pkg::op_t op,
    output logic [31:0] mem_operand,
    output logic [15:0] imm_half,
    output logic [31:0] src_reg,
    output muldiv_pkg::pair_t pair_in
);
    initial begin
        start = 1'b0;
        op = multiply_memory_half;
        {mem_operand, imm_half, src_reg, pair_in} = '0;
    end
    // pair is always an even register with its odd partner
    task automatic issue(input op_t o, input logic [31:0] m,
        input logic [15:0] i, input logic [31:0] s, input pair_t p,
        output logic ok);
        int n;
        @(posedge mclk);
        start <= 1'b1;
        op <= o;
        {mem_operand, imm_half, src_reg, pair_in} <= {m, i, s, p};
        @(posedge mclk);
        start <= 1'b0;
        // released operands flip so a stale value cannot pass
        {mem_operand, imm_half, src_reg, pair_in} <= ~{m, i, s, p};
        n = 0;
        #1;
        while (done !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        ok = (done === 1'b1);
    endtask
endmodule // seq_model
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench of the multiply/divide unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import muldiv_pkg::*;
    logic mclk, nrst, start, done, busy, irq, ok;
    op_t op;
    logic [31:0] mem_operand, src_reg, s_axi_wdata, s_axi_rdata;
    logic [15:0] imm_half;
    pair_t pair_in, result, p;
    flags_t flags;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors, comparisons, cyc, seed, k;

    muldiv_unit DUT (.mclk, .nrst, .start, .op, .mem_operand, .imm_half,
        .src_reg, .pair_in, .result, .flags, .done, .busy, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    seq_model u_seq (.mclk, .done, .start, .op, .mem_operand, .imm_half,
        .src_reg, .pair_in);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end

    task automatic chk(input logic c, input string msg);
        comparisons++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    // -------------------------------------------------------------
    // expected unit answer
    // -------------------------------------------------------------
    function automatic logic [67:0] model(op_t o, logic [31:0] m,
        logic [15:0] i, logic [31:0] s, pair_t p);
        longint a, q, r;
        logic [63:0] v;
        case (o)
            multiply_memory_half, divide_memory_half: a = $signed(m[15:0]);
            multiply_register_pair: a = $signed(s);
            multiply_immediate_op: a = $signed(i);
            divide_memory_byte: a = {56'h0, m[7:0]};
            default: a = $signed(m);
        endcase
        if (o < divide_memory_byte) begin
            v = a * longint'($signed(p.odd));
            return {v, 1'b0, $signed(v) > 0, $signed(v) < 0, v == 0};
        end
        if (a == 0) return {p, EXC_FLAGS};
        q = longint'(p) / a;
        r = longint'(p) % a;
        if (q > 64'sh7FFFFFFF || q < -64'sh80000000) return {p, EXC_FLAGS};
        return {r[31:0], q[31:0], 1'b0, q > 0, q < 0, q == 0};
    endfunction
    task automatic run(input op_t o, input logic [31:0] m,
        input logic [15:0] i, input logic [31:0] s, input pair_t p);
        u_seq.issue(o, m, i, s, p, ok);
        chk(ok === 1'b1 && {result, flags} === model(o, m, i, s, p), "unit");
    endtask
    // -------------------------------------------------------------
    // register bus master
    // -------------------------------------------------------------
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp === RESP_OKAY, "write response");
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] rs);
        int n;
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        chk({s_axi_rdata, s_axi_rresp} === {d, rs}, "read");
    endtask
    task results;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        {num_errors, comparisons, cyc} = '0;
        seed = 64892;
        nrst = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        axr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
        axr(OFS_CTRL, 32'h1, RESP_OKAY);
        axr(8'h20, 32'h0, RESP_SLVERR);
        run(multiply_memory_half, 32'hFFFD, 16'h0, 32'h0,
            64'h12345678_00000003);
        run(multiply_memory_word, 32'h80000000, 16'h0, 32'h0,
            64'h1_80000000);
        run(multiply_immediate_op, 32'h0, 16'h0100, 32'h0,
            64'h0_F37A9B15);
        run(multiply_register_pair, 32'h0, 16'h0, 32'hF,
            64'h0_0000000F);
        run(multiply_memory_word, 32'h0, 16'h0, 32'h0,
            64'h5_00000007);
        run(divide_memory_byte, 32'hFFFFFF9A, 16'h0, 32'h0,
            64'h1000);
        run(divide_memory_half, 32'hFFF8, 16'h0, 32'h0,
            64'h3B);
        run(divide_memory_word, 32'hFC000000, 16'h0, 32'h0,
            64'h039A20CF);
        // busy must stand while the iterative divide runs
        fork
            run(divide_memory_word, 32'h7, 16'h0, 32'h0,
                -64'sh20);
            begin
                repeat (4) @(posedge mclk);
                chk(busy === 1'b1, "busy in divide");
            end
        join
        run(divide_memory_word, 32'h1, 16'h0, 32'h0,
            64'h1_00000000);
        run(divide_memory_byte, 32'h100, 16'h0, 32'h0, 64'h5);
        for (k = 0; k < 60; k++) begin
            p.odd = $random(seed);
            p.even = (k % 3 == 0) ? $random(seed) : {32{p.odd[31]}};
            run(op_t'($unsigned($random(seed)) % 7), $random(seed),
                $random(seed), $random(seed), p);
        end
        // start from a clean status so the raise below is caused by the divide
        axw(OFS_IRQ_CLR, 32'h3);
        axw(OFS_IRQ_EN, 32'h3);
        chk(irq === 1'b0, "irq idle");
        run(divide_memory_byte, 32'h0, 16'h0, 32'h0, 64'h9);
        repeat (3) @(posedge mclk);
        chk(irq === 1'b1, "irq raised");
        axr(OFS_STATUS, 32'h3, RESP_OKAY);
        axr(OFS_UNIT_STATE, 32'h8, RESP_OKAY);
        axw(OFS_IRQ_CLR, 32'h3);
        repeat (3) @(posedge mclk);
        chk(irq === 1'b0, "irq cleared");
        axr(OFS_STATUS, 32'h0, RESP_OKAY);
        axw(OFS_IRQ_EN, 32'h0);
        run(multiply_memory_word, 32'h3, 16'h0, 32'h0, 64'h2);
        repeat (3) @(posedge mclk);
        chk(irq === 1'b0, "irq masked");
        axw(OFS_CTRL, 32'h0);
        u_seq.issue(multiply_memory_word, 32'h3, 16'h0, 32'h0,
            64'h2, ok);
        chk(ok === 1'b0, "disabled unit answered");
        results();
    end
endmodule // tb_top
`default_nettype wire
